/* File: hdl/asp_ctrl.sv */
// controller that drives a 32k x 8 asynchronous static memory
// How it works
// - write lasts while select and strobe low
// - reads spaced 12 ns, data by 12 ns
// - write cycle at least 12 ns
// - write pulse low at least 8 ns
// - address and select 10 ns before end
// - write data stable 8 ns before end
// - zero address setup and recovery allowed
// - wait 5 ms after retention before access
`timescale 1ns/1ps
`default_nettype none
`include "asp_params.svh"
module asp_ctrl
#(
   parameter int RECOVER_CYC = `ASP_RECOVER_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic retain,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire asp_pkg::asp_addr_t req_addr,
   input wire asp_pkg::asp_data_t req_wdata,
   output logic rsp_valid,
   output asp_pkg::asp_data_t rsp_rdata,
   output logic cs_n,
   output logic oe_n,
   output logic we_n,
   output asp_pkg::asp_addr_t word_select_bus,
   input wire asp_pkg::asp_data_t byte_lines_i,
   output asp_pkg::asp_data_t byte_lines_o,
   output logic byte_lines_oe
);
   // ************************************************************
   // sequencer state
   // ************************************************************
   asp_pin_if pin ();
   asp_pkg::asp_state_e state_r;
   logic [22:0] cnt_r;
   asp_pkg::asp_addr_t addr_r;
   asp_pkg::asp_data_t wdata_r;
   logic did_write_r;

   // every strobe leaves through the pin register, so pins lag the state by one cycle;
   // the counts below are measured on the state and the lag is added where it matters
   // a 23-bit counter covers the full recovery wait at the nominal clock
   localparam logic [22:0] RD_CYC = 23'(`ASP_RD_CYC);
   localparam logic [22:0] WP_CYC = 23'(`ASP_WP_CYC);
   localparam logic [22:0] TURN_CYC = 23'(`ASP_TURN_CYC);
   localparam logic [22:0] REC_CYC = 23'(RECOVER_CYC);

   // requests only taken when idle and not in retention
   // limitation: retain raised in mid-access lets that access finish first,
   // so the supply must not drop before the memory is deselected
   assign req_ready = (state_r == asp_pkg::asp_idle) && !retain;

   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         state_r <= asp_pkg::asp_wait;
         cnt_r <= '0;
      end
      else
      begin
         case (state_r)
            asp_pkg::asp_wait:
            begin
               // retention restarts the full recovery wait
               if (retain)
                  cnt_r <= '0;
               else if (cnt_r >= REC_CYC - 23'h00_0001)
               begin
                  state_r <= asp_pkg::asp_idle;
                  cnt_r <= '0;
               end
               else
                  cnt_r <= cnt_r + 23'h00_0001;
            end
            asp_pkg::asp_idle:
            begin
               cnt_r <= '0;
               if (retain)
                  state_r <= asp_pkg::asp_wait;
               else if (req_valid)
                  state_r <= req_write ? asp_pkg::asp_wr : asp_pkg::asp_rd;
            end
            asp_pkg::asp_rd:
            begin
               // one extra cycle covers the register stage before the pins
               if (cnt_r >= RD_CYC)
               begin
                  state_r <= asp_pkg::asp_turn;
                  cnt_r <= '0;
               end
               else
                  cnt_r <= cnt_r + 23'h00_0001;
            end
            asp_pkg::asp_wr:
            begin
               if (cnt_r >= WP_CYC - 23'h00_0001)
               begin
                  state_r <= asp_pkg::asp_turn;
                  cnt_r <= '0;
               end
               else
                  cnt_r <= cnt_r + 23'h00_0001;
            end
            default:
            begin
               // turnaround: device output float/recovery before next access
               if (cnt_r >= TURN_CYC - 23'h00_0001)
               begin
                  state_r <= asp_pkg::asp_idle;
                  cnt_r <= '0;
               end
               else
                  cnt_r <= cnt_r + 23'h00_0001;
            end
         endcase
      end

   // ************************************************************
   // request capture
   // ************************************************************
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         addr_r <= '0;
         wdata_r <= '0;
         did_write_r <= 1'b0;
      end
      else if (req_valid && req_ready)
      begin
         addr_r <= req_addr;
         wdata_r <= req_wdata;
         did_write_r <= req_write;
      end

   // ************************************************************
   // pin intent: address and data held through the whole cycle
   // ************************************************************
   always_comb
   begin
      pin.cs_n = 1'b1;
      pin.oe_n = 1'b1;
      pin.we_n = 1'b1;
      pin.drive = 1'b0;
      pin.addr = addr_r;
      pin.wdata = wdata_r;
      case (state_r)
         asp_pkg::asp_rd:
         begin
            pin.cs_n = 1'b0;
            pin.oe_n = 1'b0;
         end
         asp_pkg::asp_wr:
         begin
            // select and strobe fall together so the memory never drives
            pin.cs_n = 1'b0;
            pin.we_n = 1'b0;
            pin.drive = 1'b1;
         end
         asp_pkg::asp_turn:
         begin
            // data held one cycle past write end; zero hold is legal
            pin.drive = did_write_r;
         end
         default:
         begin
            pin.cs_n = 1'b1;
         end
      endcase
   end

   asp_pin_drv u_drv
   (
      .clk(clk),
      .rst(rst),
      .p(pin.pins),
      .cs_n(cs_n),
      .oe_n(oe_n),
      .we_n(we_n),
      .word_select_bus(word_select_bus),
      .byte_lines_o(byte_lines_o),
      .byte_lines_oe(byte_lines_oe)
   );

   // ************************************************************
   // read capture at the end of the access window
   // ************************************************************
   // sampling a full cycle after the pins fall leaves wide margin over the access time;
   // the price is one extra cycle of read latency
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         if (state_r == asp_pkg::asp_rd && cnt_r >= RD_CYC)
         begin
            rsp_valid <= 1'b1;
            rsp_rdata <= byte_lines_i;
         end
      end
endmodule // asp_ctrl
`default_nettype wire

/* File: hdl/asp_params.svh */
// timing and geometry constants for the static memory port controller
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
`define ASP_ADDR_W 15
`define ASP_DATA_W 8
`define ASP_CLK_PS 50000
`define ASP_T_RC_PS 12000
`define ASP_T_AA_PS 12000
`define ASP_T_WC_PS 12000
`define ASP_T_WP_PS 8000
`define ASP_T_CW_PS 10000
`define ASP_T_DW_PS 8000
`define ASP_T_OW_PS 5000
`define ASP_T_OHZ_PS 6000
`define ASP_T_R_MS 5
// least times round up, none below one cycle
`define ASP_CYC(t) ((((t) + `ASP_CLK_PS - 1) / `ASP_CLK_PS) < 1 ? 1 : (((t) + `ASP_CLK_PS - 1) / `ASP_CLK_PS))
`define ASP_RD_CYC `ASP_CYC(`ASP_T_AA_PS)
`define ASP_WP_CYC `ASP_CYC(`ASP_T_WP_PS > `ASP_T_CW_PS ? `ASP_T_WP_PS : `ASP_T_CW_PS)
`define ASP_TURN_CYC `ASP_CYC(`ASP_T_OHZ_PS > `ASP_T_OW_PS ? `ASP_T_OHZ_PS : `ASP_T_OW_PS)
// cycles per millisecond first: 5 ms in picoseconds would overflow a 32-bit integer
`define ASP_RECOVER_CYC (`ASP_T_R_MS * (1000000000 / `ASP_CLK_PS))
`endif

/* File: hdl/asp_pin_drv.sv */
// registered pin stage: all strobes, address and data leave from flip-flops
`timescale 1ns/1ps
`default_nettype none
module asp_pin_drv
(
   input wire logic clk,
   input wire logic rst,
   asp_pin_if.pins p,
   output logic cs_n,
   output logic oe_n,
   output logic we_n,
   output asp_pkg::asp_addr_t word_select_bus,
   output asp_pkg::asp_data_t byte_lines_o,
   output logic byte_lines_oe
);
   // registering keeps strobe, address and data edges aligned to one clock edge
   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         cs_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         byte_lines_oe <= 1'b0;
      end
      else
      begin
         cs_n <= p.cs_n;
         oe_n <= p.oe_n;
         we_n <= p.we_n;
         byte_lines_oe <= p.drive;
      end

   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         word_select_bus <= '0;
         byte_lines_o <= '0;
      end
      else
      begin
         word_select_bus <= p.addr;
         byte_lines_o <= p.wdata;
      end
endmodule // asp_pin_drv
`default_nettype wire

/* File: hdl/asp_pin_if.sv */
// pin bundle between the sequencer and the pin driver
`timescale 1ns/1ps
`default_nettype none
interface asp_pin_if;
   logic cs_n;
   logic oe_n;
   logic we_n;
   logic drive;
   asp_pkg::asp_addr_t addr;
   asp_pkg::asp_data_t wdata;
   modport seq (output cs_n, output oe_n, output we_n, output drive, output addr, output wdata);
   modport pins (input cs_n, input oe_n, input we_n, input drive, input addr, input wdata);
endinterface
`default_nettype wire

/* File: hdl/asp_pkg.sv */
// types shared by the static memory port controller
`include "asp_params.svh"
package asp_pkg;
   typedef logic [`ASP_ADDR_W-1:0] asp_addr_t;
   typedef logic [`ASP_DATA_W-1:0] asp_data_t;
   typedef enum logic [2:0] {asp_wait, asp_idle, asp_rd, asp_wr, asp_turn} asp_state_e;
endpackage

/* File: test/asp_ctrl_monitor.sv */
// pin-level checker for the static memory port controller
`timescale 1ns/1ps
`default_nettype none
module asp_ctrl_monitor
#(
   parameter int RECOVER_CYC = 4
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic retain,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_write,
   input wire logic cs_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic byte_lines_oe,
   input wire logic rsp_valid
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [31:0] wait_r;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wait_r <= 32'h0000_0000;
      else if (retain)
         wait_r <= 32'h0000_0000;
      else if (wait_r < RECOVER_CYC)
         wait_r <= wait_r + 32'h0000_0001;
   end
   property p_rd_take;
      req_valid && req_ready && !req_write |-> ##2 ($fell(oe_n) && !cs_n && we_n);
   endproperty
   a_rd_take: assert property (p_rd_take) else $error("read not launched");
   property p_rd_win;
      $fell(oe_n) |-> ##1 (!oe_n && !cs_n) ##1 (oe_n && cs_n);
   endproperty
   a_rd_win: assert property (p_rd_win) else $error("read window length");
   property p_rsp;
      $fell(oe_n) |-> ##[1:2] rsp_valid;
   endproperty
   a_rsp: assert property (p_rsp) else $error("read answer missing");
   property p_rsp_pulse;
      rsp_valid |=> !rsp_valid;
   endproperty
   a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer too long");
   property p_wr_take;
      req_valid && req_ready && req_write |-> ##2 ($fell(we_n) && $fell(cs_n) && oe_n && byte_lines_oe);
   endproperty
   a_wr_take: assert property (p_wr_take) else $error("write not launched");
   property p_wr_end;
      $fell(we_n) |-> ##1 (we_n && cs_n && byte_lines_oe) ##1 !byte_lines_oe;
   endproperty
   a_wr_end: assert property (p_wr_end) else $error("write end or turn wrong");
   property p_no_fight;
      !oe_n |-> !byte_lines_oe;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("both ends drive");
   property p_busy;
      req_valid && req_ready |=> !req_ready;
   endproperty
   a_busy: assert property (p_busy) else $error("ready after take");
   property p_recover;
      req_ready |-> wait_r >= RECOVER_CYC;
   endproperty
   a_recover: assert property (p_recover) else $error("access before recovery");
   property p_retain;
      retain [*3] |-> cs_n && !req_ready;
   endproperty
   a_retain: assert property (p_retain) else $error("selected in retention");
endmodule // asp_ctrl_monitor
bind asp_ctrl asp_ctrl_monitor #(.RECOVER_CYC(RECOVER_CYC)) i_mon (.clk(clk), .rst(rst), .retain(retain),
   .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .cs_n(cs_n), .oe_n(oe_n),
   .we_n(we_n), .byte_lines_oe(byte_lines_oe), .rsp_valid(rsp_valid));
`default_nettype wire

/* File: test/asp_ctrl_tb.sv */
// self-checking bench for the static memory port controller
`timescale 1ns/1ps
`default_nettype none
module asp_ctrl_tb;
   localparam int RCV = 4;
   logic clk = 1'b0, rst = 1'b1, retain = 1'b0, req_valid = 1'b0, req_write = 1'b0, slow = 1'b0;
   asp_pkg::asp_addr_t req_addr = 15'h0000;
   asp_pkg::asp_data_t req_wdata = 8'h00;
   logic req_ready, rsp_valid, cs_n, oe_n, we_n, byte_lines_oe;
   asp_pkg::asp_data_t rsp_rdata, byte_lines_o, byte_lines_i;
   asp_pkg::asp_addr_t word_select_bus;
   int fail_count = 0, total_checks = 0;
   initial forever #25 clk = ~clk;
   asp_ctrl #(.RECOVER_CYC(RCV)) i_dut (.clk(clk), .rst(rst), .retain(retain), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
      .word_select_bus(word_select_bus), .byte_lines_i(byte_lines_i), .byte_lines_o(byte_lines_o),
      .byte_lines_oe(byte_lines_oe));
   asp_sram_model i_mem (.clk(clk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .addr(word_select_bus),
      .din(byte_lines_o), .din_oe(byte_lines_oe), .slow(slow), .dout(byte_lines_i));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // called at a falling edge; request is held across exactly one taking edge
   task automatic issue(input logic wr, input logic [14:0] a, input logic [7:0] d);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      chk(req_ready, 16'h0001);
      if (req_ready !== 1'b1)
         end_of_test();
      req_valid = 1'b1;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] exp);
      int n;
      issue(1'b0, a, 8'h00);
      n = 0;
      while (rsp_valid !== 1'b1 && n < 8)
      begin
         @(negedge clk);
         n++;
      end
      chk(rsp_valid, 16'h0001);
      if (rsp_valid !== 1'b1)
         end_of_test();
      chk(rsp_rdata, exp);
   endtask
   task automatic t_pins();
      issue(1'b1, 15'h1234, 8'hC3);
      @(negedge clk);
      chk({cs_n, oe_n, we_n, byte_lines_oe}, 16'h0005);
      chk(word_select_bus, 16'h1234);
      chk(byte_lines_o, 16'h00C3);
      issue(1'b0, 15'h1234, 8'h00);
      @(negedge clk);
      chk({cs_n, oe_n, we_n, byte_lines_oe}, 16'h0002);
      chk(word_select_bus, 16'h1234);
      @(negedge clk);
      chk({rsp_valid, rsp_rdata}, 16'h01C3);
   endtask
   task automatic t_reset();
      chk({cs_n, oe_n, we_n, byte_lines_oe, req_ready}, 16'h001C);
      repeat (RCV - 2) @(negedge clk);
      chk(req_ready, 16'h0000);
   endtask
   task automatic t_rw();
      logic [14:0] a [4] = '{15'h0000, 15'h7FFF, 15'h5555, 15'h2AAA};
      logic [7:0] d [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h01};
      for (int i = 0; i < 4; i++)
         issue(1'b1, a[i], d[i]);
      for (int i = 0; i < 4; i++)
         rd(a[i], d[i]);
      slow = 1'b1;
      for (int i = 0; i < 4; i++)
         rd(a[i], d[i]);
      issue(1'b1, 15'h7FFF, 8'h3C);
      rd(15'h7FFF, 8'h3C);
      rd(15'h7FFF, 8'h3C);
      rd(15'h0000, 8'hA5);
   endtask
   task automatic t_retain();
      retain = 1'b1;
      repeat (3) @(negedge clk);
      chk({cs_n, req_ready}, 16'h0002);
      retain = 1'b0;
      repeat (RCV - 2) @(negedge clk);
      chk(req_ready, 16'h0000);
      rd(15'h2AAA, 8'h01);
   endtask
   initial
   begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_rw();
      t_pins();
      t_retain();
      end_of_test();
   end
endmodule // asp_ctrl_tb
`default_nettype wire

/* File: test/asp_sram_model.sv */
// behavioural 32k x 8 static memory standing on the controller's pins
`timescale 1ns/1ps
`default_nettype none
module asp_sram_model
(
   input wire logic clk,
   input wire logic cs_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire asp_pkg::asp_addr_t addr,
   input wire asp_pkg::asp_data_t din,
   input wire logic din_oe,
   input wire logic slow,
   output wire asp_pkg::asp_data_t dout
);
   asp_pkg::asp_data_t mem [0:32767];
   asp_pkg::asp_data_t last_r = 8'h00;
   asp_pkg::asp_data_t late;
   logic rd_en;
   assign rd_en = !cs_n && !oe_n && we_n;
   // slowest legal access, so a controller sampling too early sees stale data
   assign #12 late = mem[addr];
   // released wire shows the inverse of its last level rather than a lucky match
   assign dout = din_oe ? din : rd_en ? (slow ? late : mem[addr]) : ~last_r;
   always @(posedge clk)
   begin
      if (!cs_n && !we_n)
         mem[addr] <= dout;
      last_r <= dout;
   end
endmodule // asp_sram_model
`default_nettype wire
